// file: pkg/lcdsp_pkg.sv
`default_nettype none
package lcdsp_pkg;
    // ========================================
    // Serial framing
    localparam int WORD_BITS      = 16;
    localparam int KEY_TURN_BITS  = 8;
    localparam int BIT_CNT_W      = 5;

    // ========================================
    // Upper-byte opcodes
    localparam logic [7:0] OP_DD_WRITE    = 8'h98;
    localparam logic [7:0] OP_SMALL_WRITE = 8'h90;
    localparam logic [7:0] OP_SET_DDMK    = 8'h93;
    localparam logic [7:0] OP_KEY_READ    = 8'hA7;

    // ========================================
    // Address map
    localparam logic [7:0] DD_FIRST        = 8'h00;
    localparam logic [7:0] DD_LAST         = 8'h0D;
    localparam logic [7:0] MK_FIRST        = 8'h10;
    localparam logic [7:0] MK_LAST         = 8'h1D;
    localparam logic [7:0] MK_HIDDEN_FIRST = 8'h1C;
    localparam int         DD_DEPTH        = 14;
    localparam int         MK_DEPTH        = 14;
    localparam int         MK_SHOWN        = 12;
    localparam int         CG_DEPTH        = 256;
    localparam int         SMALL_BITS      = 5;

    // ========================================
    // Reset values
    localparam logic [7:0] AC_RESET = 8'h00;

    // ========================================
    // Timing
    localparam int CLK_PERIOD_PS  = 5000;
    localparam int OSC_PERIOD_PS  = 6900000;
    localparam int OSC_CYCLES     = OSC_PERIOD_PS / CLK_PERIOD_PS;
    localparam int DUTY_COMMONS   = 8;
    localparam int TICKS_PER_COM  = 16;

    // ========================================
    // Types
    typedef enum logic [1:0] {
        SER_IDLE   = 2'b00,
        SER_SHIFT  = 2'b01,
        SER_FULL   = 2'b11,
        SER_KEYOUT = 2'b10
    } lcdsp_ser_t;

    typedef enum logic {
        TGT_DDMK  = 1'b0,
        TGT_GLYPH = 1'b1
    } lcdsp_target_t;
endpackage
`default_nettype wire

// file: design/lcdsp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module lcdsp_sync #(
    parameter int W = 4
) (
    input  wire logic         clk,   // System clock
    input  wire logic         rstn,  // Async reset, active low
    input  wire logic [W-1:0] d,     // Asynchronous levels
    output logic      [W-1:0] q      // Synchronised levels
);
    logic [W-1:0] meta;

    // Stage one feeds stage two only
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= '1;
            q    <= '1;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule
`default_nettype wire

// file: design/lcdsp_osc.sv
`timescale 1ns/1ps
`default_nettype none
module lcdsp_osc #(
    parameter int OSC_CYC = lcdsp_pkg::OSC_CYCLES,
    parameter int COM_TKS = lcdsp_pkg::TICKS_PER_COM,
    parameter int COMS    = lcdsp_pkg::DUTY_COMMONS
) (
    input  wire logic       clk,         // System clock
    input  wire logic       rstn,        // Async reset, active low
    output logic            osc_tick,    // One pulse per oscillator period
    output logic [2:0]      com_sel,     // Active common line
    output logic            frame_start  // Pulse at common zero
);
    logic [10:0] osc_cnt;
    logic [7:0]  tick_cnt;

    // ========================================
    // Oscillator period from the system clock
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            osc_cnt  <= 11'h000;
            osc_tick <= 1'b0;
        end else if (osc_cnt == 11'(OSC_CYC - 1)) begin
            osc_cnt  <= 11'h000;
            osc_tick <= 1'b1;
        end else begin
            osc_cnt  <= osc_cnt + 11'h001;
            osc_tick <= 1'b0;
        end
    end

    // ========================================
    // One in eight common scan
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tick_cnt    <= 8'h00;
            com_sel     <= 3'h0;
            frame_start <= 1'b0;
        end else begin
            frame_start <= 1'b0;
            if (osc_tick) begin
                if (tick_cnt == 8'(COM_TKS - 1)) begin
                    tick_cnt <= 8'h00;
                    if (com_sel == 3'(COMS - 1)) begin
                        com_sel     <= 3'h0;
                        frame_start <= 1'b1;
                    end else begin
                        com_sel <= com_sel + 3'h1;
                    end
                end else begin
                    tick_cnt <= tick_cnt + 8'h01;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: design/lcdsp_top.sv
// How it works
// [R1] Display write stores the whole low byte at the current address.
// [R2] Glyph or icon write stores only the low five data bits.
// [R3] Target RAM follows the last address-setting instruction kind.
// [R4] Each RAM data write steps the address up or down per entry mode.
// [R5] Each RAM data write also shifts the display when entry mode asks.
// [R6] Icon locations 1C and 1D store and step but never show.
// [R7] Display write opcode is 98 hex in the upper byte.
// [R8] Icon and glyph writes share opcode 90 hex, data in bits 4..0.
// [R9] Key read opcode A7 hex; answer is four low keys, zero, three high.
// [R10] Data pin turns to output at the eighth falling shift clock.
// [R11] Shift clock and data are ignored while chip select is high.
// [R12] One word is sixteen bits within one chip select low period.
// [R13] Incoming bits are sampled on shift clock rising edges.
// [R14] First sixteen bits are taken at chip select rise; extra ignored.
// [R15] Fewer than sixteen bits at chip select rise: nothing runs.
// [R16] Host clocks exactly sixteen bits per chip select low period.
// [R17] Words travel most significant bit first.
// [R18] Host initialises by instructions when power-up reset is unsure.
// [R19] Host uses software initialisation when icons are in use.
// [R20] Frame timing derives from a nominal 145 kHz oscillator.
// [R21] Commons scan at one in eight duty.
// [R22] Display RAM at 00..0D, icon RAM at 10..1D, shared counter.
// [R23] Key bits leave MSB first, changing after each falling edge.
`timescale 1ns/1ps
`default_nettype none
module lcdsp_top #(
    parameter int CG_DEPTH = lcdsp_pkg::CG_DEPTH
) (
    input  wire logic       clk,            // System clock, 200 MHz
    input  wire logic       rstn,           // Async reset, active low
    input  wire logic       sck_pin,        // Shift clock pin
    input  wire logic       cs_n_pin,       // Chip select pin, active low
    input  wire logic       sdata_in,       // Data pin, input side
    output logic            sdata_out,      // Data pin, output side
    output logic            sdata_oe_n,     // Data pin drive, low = drive
    input  wire logic       ac_sel_pin,     // High selects glyph address
    input  wire logic       entry_inc,      // Entry mode: 1 step up
    input  wire logic       entry_shift,    // Entry mode: shift on write
    input  wire logic [3:0] key_low,        // Low key row bits
    input  wire logic [2:0] key_high,       // High key bits
    input  wire logic [3:0] disp_rd_addr,   // Display RAM read index
    output logic      [7:0] disp_rd_data,   // Display RAM read data
    input  wire logic [3:0] icon_rd_addr,   // Icon RAM read index
    output logic      [4:0] icon_rd_data,   // Icon RAM shown data
    input  wire logic [7:0] glyph_rd_addr,  // Glyph RAM read address
    output logic      [4:0] glyph_rd_data,  // Glyph RAM read data
    output logic      [7:0] addr_count,     // Address counter
    output logic            glyph_target,   // Writes go to glyph RAM
    output logic            disp_shift,     // One-cycle display shift
    output logic            disp_shift_left,// Shift direction
    output logic            word_done,      // One-cycle word accepted
    output logic            word_dropped,   // One-cycle short word
    output logic      [2:0] com_sel,        // Active common line
    output logic            frame_start     // Frame start pulse
);
    // ========================================
    // Pin synchronisers
    logic [3:0] pins_s;
    logic       sck_s;
    logic       cs_n_s;
    logic       sd_s;
    logic       ac_sel_s;
    logic       sck_d;
    logic       cs_n_d;

    lcdsp_sync #(.W(4)) u_sync (
        .clk  (clk),
        .rstn (rstn),
        .d    ({ac_sel_pin, sdata_in, cs_n_pin, sck_pin}),
        .q    (pins_s)
    );

    assign sck_s    = pins_s[0];
    assign cs_n_s   = pins_s[1];
    assign sd_s     = pins_s[2];
    assign ac_sel_s = pins_s[3];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sck_d  <= 1'b1;
            cs_n_d <= 1'b1;
        end else begin
            sck_d  <= sck_s;
            cs_n_d <= cs_n_s;
        end
    end

    logic cs_low;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;

    assign cs_low   = ~cs_n_s;
    assign cs_rise  = cs_n_s & ~cs_n_d;
    assign sck_rise = sck_s & ~sck_d;
    assign sck_fall = ~sck_s & sck_d;

    // ========================================
    // Serial receiver
    lcdsp_pkg::lcdsp_ser_t state;
    logic [15:0]           shreg;
    logic [4:0]            bit_cnt;
    logic [7:0]            key_out;
    logic                  word_valid;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state   <= lcdsp_pkg::SER_IDLE;
            shreg   <= 16'h0000;
            bit_cnt <= 5'h00;
            key_out <= 8'h00;
        end else if (!cs_low) begin
            state   <= lcdsp_pkg::SER_IDLE;                // R11
            bit_cnt <= 5'h00;
        end else begin
            case (state)
                lcdsp_pkg::SER_IDLE,
                lcdsp_pkg::SER_SHIFT: begin
                    state <= lcdsp_pkg::SER_SHIFT;
                    if (sck_rise) begin
                        shreg   <= {shreg[14:0], sd_s};    // R13 R17
                        bit_cnt <= bit_cnt + 5'h01;
                        if (bit_cnt == 5'(lcdsp_pkg::WORD_BITS - 1)) begin
                            state <= lcdsp_pkg::SER_FULL;
                        end
                    end else if (sck_fall &&
                        bit_cnt == 5'(lcdsp_pkg::KEY_TURN_BITS) &&
                        shreg[7:0] == lcdsp_pkg::OP_KEY_READ) begin
                        state   <= lcdsp_pkg::SER_KEYOUT;  // R10
                        key_out <= {key_low, 1'b0, key_high}; // R9
                    end
                end
                lcdsp_pkg::SER_KEYOUT: begin
                    // Host keeps clocking; the word fills but runs nothing
                    if (sck_rise &&
                        bit_cnt < 5'(lcdsp_pkg::WORD_BITS)) begin
                        shreg   <= {shreg[14:0], sd_s};
                        bit_cnt <= bit_cnt + 5'h01;
                    end
                    if (sck_fall) begin
                        key_out <= {key_out[6:0], 1'b0};   // R23
                    end
                end
                lcdsp_pkg::SER_FULL: begin
                    state <= lcdsp_pkg::SER_FULL;          // R14
                end
                default: begin
                    state <= lcdsp_pkg::SER_IDLE;
                end
            endcase
        end
    end

    assign sdata_out  = key_out[7];                        // R23
    assign sdata_oe_n = (state != lcdsp_pkg::SER_KEYOUT);  // R10

    // Count is still the frame's own at the edge where cs rises
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            word_valid   <= 1'b0;
            word_dropped <= 1'b0;
        end else begin
            word_valid   <= cs_rise &&
                bit_cnt == 5'(lcdsp_pkg::WORD_BITS);       // R12 R14
            word_dropped <= cs_rise && bit_cnt != 5'h00 &&
                bit_cnt < 5'(lcdsp_pkg::WORD_BITS);        // R15
        end
    end

    assign word_done = word_valid;

    // ========================================
    // Instruction decode
    function automatic logic in_disp(input logic [7:0] a);
        in_disp = (a >= lcdsp_pkg::DD_FIRST) && (a <= lcdsp_pkg::DD_LAST);
    endfunction

    function automatic logic in_icon(input logic [7:0] a);
        in_icon = (a >= lcdsp_pkg::MK_FIRST) && (a <= lcdsp_pkg::MK_LAST);
    endfunction

    logic [7:0]               opcode;
    logic                     is_small;
    logic                     set_ddmk;
    logic                     set_glyph;
    logic                     small_wr;
    logic                     dd_wr;
    logic                     ram_wr;
    logic                     dd_we;
    logic                     mk_we;
    logic                     cg_we;
    lcdsp_pkg::lcdsp_target_t target;

    assign opcode    = shreg[15:8];
    assign is_small  = word_valid && opcode == lcdsp_pkg::OP_SMALL_WRITE;
    assign set_glyph = is_small && ac_sel_s;
    assign small_wr  = is_small && !ac_sel_s;                // R8
    assign set_ddmk  = word_valid && opcode == lcdsp_pkg::OP_SET_DDMK;
    assign dd_wr     = word_valid && opcode == lcdsp_pkg::OP_DD_WRITE; // R7
    assign ram_wr    = dd_wr || small_wr;
    assign dd_we     = dd_wr && target == lcdsp_pkg::TGT_DDMK &&
                       in_disp(addr_count);                  // R3 R22
    assign mk_we     = small_wr && target == lcdsp_pkg::TGT_DDMK &&
                       in_icon(addr_count);                  // R3 R22
    assign cg_we     = small_wr && target == lcdsp_pkg::TGT_GLYPH; // R3

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            target <= lcdsp_pkg::TGT_DDMK;
        end else if (set_ddmk) begin
            target <= lcdsp_pkg::TGT_DDMK;                   // R3
        end else if (set_glyph) begin
            target <= lcdsp_pkg::TGT_GLYPH;
        end
    end

    assign glyph_target = (target == lcdsp_pkg::TGT_GLYPH);

    // ========================================
    // Address counter and display shift
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            addr_count <= lcdsp_pkg::AC_RESET;
        end else if (set_ddmk) begin
            addr_count <= {3'h0, shreg[4:0]};
        end else if (set_glyph) begin
            addr_count <= shreg[7:0];
        end else if (ram_wr) begin
            addr_count <= entry_inc ? addr_count + 8'h01
                                    : addr_count - 8'h01;   // R4 R6
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            disp_shift      <= 1'b0;
            disp_shift_left <= 1'b0;
        end else begin
            disp_shift <= ram_wr && entry_shift;            // R5
            if (ram_wr) begin
                disp_shift_left <= entry_inc;
            end
        end
    end

    // ========================================
    // RAM arrays, not reset
    logic [7:0] disp_ram  [lcdsp_pkg::DD_DEPTH];
    logic [4:0] icon_ram  [lcdsp_pkg::MK_DEPTH];
    logic [4:0] glyph_ram [CG_DEPTH];

    always_ff @(posedge clk) begin
        if (dd_we) begin
            disp_ram[addr_count[3:0]] <= shreg[7:0];        // R1
        end
        if (mk_we) begin
            icon_ram[addr_count[3:0]] <= shreg[4:0];        // R2
        end
        if (cg_we) begin
            glyph_ram[addr_count] <= shreg[4:0];            // R2
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            disp_rd_data  <= 8'h00;
            icon_rd_data  <= 5'h00;
            glyph_rd_data <= 5'h00;
        end else begin
            disp_rd_data <= (disp_rd_addr <= lcdsp_pkg::DD_LAST[3:0]) ?
                disp_ram[disp_rd_addr] : 8'h00;
            // Last two icon cells are scratch and never reach the panel
            icon_rd_data <= (icon_rd_addr < 4'(lcdsp_pkg::MK_SHOWN)) ?
                icon_ram[icon_rd_addr] : 5'h00;             // R6
            glyph_rd_data <= glyph_ram[glyph_rd_addr];
        end
    end

    // ========================================
    // Oscillator and common scan
    lcdsp_osc u_osc (
        .clk         (clk),
        .rstn        (rstn),
        .osc_tick    (),
        .com_sel     (com_sel),                             // R20 R21
        .frame_start (frame_start)
    );

    // ========================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence s_full_frame;
        cs_rise && bit_cnt == 5'(lcdsp_pkg::WORD_BITS);
    endsequence

    sequence s_key_turn;
        cs_low && sck_fall && bit_cnt == 5'(lcdsp_pkg::KEY_TURN_BITS) &&
        shreg[7:0] == lcdsp_pkg::OP_KEY_READ &&
        state == lcdsp_pkg::SER_SHIFT;
    endsequence

    a_word_accept: assert property (s_full_frame |=> word_valid) // R14
        else $error("full word not accepted");

    a_short_drop: assert property ( // R15
        cs_rise && bit_cnt != 5'h00 && bit_cnt < 5'(lcdsp_pkg::WORD_BITS)
        |=> word_dropped && !ram_wr)
        else $error("short word executed");

    a_idle_ignore: assert property ( // R11
        !cs_low |=> bit_cnt == 5'h00 && $stable(shreg))
        else $error("lines not ignored with cs high");

    a_msb_shift: assert property ( // R13 R17
        cs_low && sck_rise && bit_cnt < 5'(lcdsp_pkg::WORD_BITS) &&
        state != lcdsp_pkg::SER_FULL
        |=> shreg[0] == $past(sd_s) &&
            shreg[15:1] == $past(shreg[14:0]))
        else $error("bit not shifted in msb first");

    a_key_turn: assert property ( // R10
        s_key_turn |=> !sdata_oe_n && sdata_out == $past(key_low[3])
        ##1 (!sdata_oe_n || !cs_low))
        else $error("data pin did not turn at eighth fall");

    a_key_shift: assert property ( // R23
        state == lcdsp_pkg::SER_KEYOUT && cs_low && sck_fall
        |=> sdata_out == $past(key_out[6]))
        else $error("key bit order wrong");

    a_disp_write: assert property ( // R1
        dd_we |=> disp_ram[$past(addr_count[3:0])] == $past(shreg[7:0]))
        else $error("display byte not stored");

    a_glyph_write: assert property ( // R2
        cg_we |=> glyph_ram[$past(addr_count)] == $past(shreg[4:0]))
        else $error("glyph bits not stored");

    a_addr_step: assert property ( // R4
        ram_wr && entry_inc |=> addr_count == $past(addr_count) + 8'h01)
        else $error("address not stepped up");

    a_addr_down: assert property ( // R4
        ram_wr && !entry_inc |=> addr_count == $past(addr_count) - 8'h01)
        else $error("address not stepped down");

    a_shift_follow: assert property ( // R5
        ram_wr |=> disp_shift == $past(entry_shift))
        else $error("display shift mismatch");

    a_icon_hidden: assert property ( // R6
        icon_rd_addr >= 4'(lcdsp_pkg::MK_SHOWN) |=> icon_rd_data == 5'h00)
        else $error("hidden icon cell shown");

    a_target_pick: assert property ( // R3
        set_ddmk || set_glyph |=> glyph_target == $past(set_glyph))
        else $error("wrong RAM targeted");
endmodule
`default_nettype wire

// file: bench/lcdsp_host.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Host side of the serial link
module lcdsp_host (
    output logic      sck,    // Shift clock, idles high
    output logic      cs_n,   // Chip select, active low
    output logic      d_out,  // Data driven by host
    output logic      d_en,   // Host drives data line
    input  wire logic d_wire  // Resolved data line
);
    initial begin
        sck   = 1'b1;
        cs_n  = 1'b1;
        d_out = 1'b0;
        d_en  = 1'b0;
    end

    // One frame of n bits; key set turns the line at the fall after the 8th rise
    task automatic xfer(input logic [31:0] w, input int n, input logic key,
                        output logic [7:0] rd);
        rd   = 8'h00;
        cs_n = 1'b0;
        d_en = 1'b1;
        #40;
        for (int i = 0; i < n; i++) begin
            sck = 1'b0;
            if (key && i == 8)
                d_en = 1'b0;
            d_out = w[n-1-i];
            #32 sck = 1'b1;
            if (key && i >= 8)
                rd = {rd[6:0], d_wire};
            #32;
        end
        cs_n  = 1'b1;
        d_en  = 1'b0;
        // Released line is pulled up; stale data would hide faults
        d_out = ~d_out;
        #100;
    endtask

    // Clocks while deselected must do nothing
    task automatic idle_clocks();
        for (int i = 0; i < 16; i++) begin
            sck   = 1'b0;
            d_out = ~d_out;
            #32 sck = 1'b1;
            #32;
        end
    endtask
endmodule
`default_nettype wire

// file: bench/test_lcdsp_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_lcdsp_top;
    // One edge held in reset, one for the last tick to reach the scan
    localparam int COM_STEP =
        lcdsp_pkg::OSC_CYCLES * lcdsp_pkg::TICKS_PER_COM + 2;
    typedef struct {
        logic [31:0] w;
        int          n;
        logic        sel;
        logic        inc;
        logic        sh;
        logic [7:0]  addr;
        logic        drop;
    } lcdsp_row_t;

    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic       sck, cs_n, h_d, h_en, data_wire;
    logic       sdata_out, sdata_oe_n, ac_sel = 1'b0;
    logic       entry_inc = 1'b1, entry_shift = 1'b0;
    logic [3:0] key_low = 4'h0, disp_rd_addr = 4'h0, icon_rd_addr = 4'h0;
    logic [2:0] key_high = 3'h0;
    logic [2:0] com_sel;
    logic       frame_start;
    logic [7:0] glyph_rd_addr = 8'h00, disp_rd_data, addr_count, rd;
    logic [4:0] icon_rd_data, glyph_rd_data;
    logic       glyph_target, disp_shift, disp_shift_left;
    logic       word_done, word_dropped;
    int         miscompares = 0, samples_checked = 0, cycles = 0;
    int         n_done = 0, n_drop = 0, n_shift = 0, n_oe = 0, d0, d1, s0;
    int         n_clash = 0, n_frame = 0, c0;
    lcdsp_row_t rows [10];

    always #2.5 clk = ~clk;
    // Pull-up on the shared data pin
    assign data_wire = !sdata_oe_n ? sdata_out : (h_en ? h_d : 1'b1);

    lcdsp_host i_lcdsp_host (.sck(sck), .cs_n(cs_n), .d_out(h_d),
                             .d_en(h_en), .d_wire(data_wire));

    lcdsp_top i_lcdsp_top (
        .clk(clk), .rstn(rstn), .sck_pin(sck), .cs_n_pin(cs_n),
        .sdata_in(data_wire), .sdata_out(sdata_out),
        .sdata_oe_n(sdata_oe_n), .ac_sel_pin(ac_sel),
        .entry_inc(entry_inc), .entry_shift(entry_shift),
        .key_low(key_low), .key_high(key_high),
        .disp_rd_addr(disp_rd_addr), .disp_rd_data(disp_rd_data),
        .icon_rd_addr(icon_rd_addr), .icon_rd_data(icon_rd_data),
        .glyph_rd_addr(glyph_rd_addr), .glyph_rd_data(glyph_rd_data),
        .addr_count(addr_count), .glyph_target(glyph_target),
        .disp_shift(disp_shift), .disp_shift_left(disp_shift_left),
        .word_done(word_done), .word_dropped(word_dropped),
        .com_sel(com_sel), .frame_start(frame_start));

    // ========================================
    // Pulse counters and timeout
    always @(posedge clk) begin
        cycles  <= cycles + 1;
        n_done  <= n_done + int'(word_done === 1'b1);
        n_drop  <= n_drop + int'(word_dropped === 1'b1);
        n_shift <= n_shift + int'(disp_shift === 1'b1);
        n_oe    <= n_oe + int'(sdata_oe_n === 1'b0);
        n_clash <= n_clash + int'(h_en === 1'b1 && sdata_oe_n === 1'b0);
        n_frame <= n_frame + int'(frame_start === 1'b1);
        if (cycles == 40000) begin
            miscompares++;
            summarize();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic peek(input logic [3:0] da, input logic [3:0] ia,
                        input logic [7:0] ga);
        @(posedge clk);
        disp_rd_addr  <= da;
        icon_rd_addr  <= ia;
        glyph_rd_addr <= ga;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic summarize();
        $display("miscompares=%0d samples_checked=%0d",
                 miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        rows[0] = '{32'h930D, 16, 1'b0, 1'b0, 1'b0, 8'h0D, 1'b0};
        rows[1] = '{32'h98A5, 16, 1'b0, 1'b0, 1'b0, 8'h0C, 1'b0};
        rows[2] = '{32'h931C, 16, 1'b0, 1'b1, 1'b0, 8'h1C, 1'b0};
        rows[3] = '{32'h90FF, 16, 1'b0, 1'b1, 1'b0, 8'h1D, 1'b0};
        rows[4] = '{32'h9310, 16, 1'b0, 1'b1, 1'b0, 8'h10, 1'b0};
        rows[5] = '{32'h90EB, 16, 1'b0, 1'b1, 1'b1, 8'h11, 1'b0};
        rows[6] = '{32'h9040, 16, 1'b1, 1'b1, 1'b0, 8'h40, 1'b0};
        rows[7] = '{32'h90F3, 16, 1'b0, 1'b1, 1'b1, 8'h41, 1'b0};
        rows[8] = '{32'h0980, 12, 1'b0, 1'b1, 1'b0, 8'h41, 1'b1};
        rows[9] = '{32'h9305F, 20, 1'b0, 1'b1, 1'b0, 8'h05, 1'b0};
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        check(addr_count, 8'h00);
        check({7'h00, sdata_oe_n}, 8'h01);
        foreach (rows[i]) begin
            @(posedge clk);
            ac_sel      <= rows[i].sel;
            entry_inc   <= rows[i].inc;
            entry_shift <= rows[i].sh;
            @(posedge clk);
            {d0, d1, s0} = {n_done, n_drop, n_shift};
            i_lcdsp_host.xfer(rows[i].w, rows[i].n, 1'b0, rd);
            check(addr_count, rows[i].addr);
            check(8'(n_done - d0), {7'h00, !rows[i].drop});
            check(8'(n_drop - d1), {7'h00, rows[i].drop});
            check(8'(n_shift - s0), {7'h00, rows[i].sh});
        end
        check({7'h00, glyph_target}, 8'h00);
        check({7'h00, disp_shift_left}, 8'h01);
        peek(4'hD, 4'h0, 8'h40);
        check(disp_rd_data, 8'hA5);
        check({3'h0, icon_rd_data}, 8'h0B);
        check({3'h0, glyph_rd_data}, 8'h13);
        peek(4'hD, 4'hC, 8'h40);
        check({3'h0, icon_rd_data}, 8'h00);
        // Deselected clocking is ignored
        d0 = n_done;
        i_lcdsp_host.idle_clocks();
        repeat (10) @(posedge clk);
        check(8'(n_done - d0), 8'h00);
        check(addr_count, 8'h05);
        // Key read with the line turned round
        @(posedge clk);
        key_low  <= 4'hA;
        key_high <= 3'h5;
        @(posedge clk);
        d0 = n_oe;
        i_lcdsp_host.xfer(32'hA700, 16, 1'b1, rd);
        check(rd, 8'hA5);
        check({7'h00, n_oe > d0}, 8'h01);
        check({7'h00, sdata_oe_n}, 8'h01);
        check(addr_count, 8'h05);
        check(8'(n_clash), 8'h00);
        peek(4'hE, 4'hC, 8'h40);
        check(disp_rd_data, 8'h00);
        // Reset between frames, then time one common step
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        check(addr_count, 8'h00);
        check({5'h00, com_sel}, 8'h00);
        check({7'h00, sdata_oe_n}, 8'h01);
        rstn <= 1'b1;
        c0 = cycles;
        while (com_sel !== 3'h1) @(posedge clk);
        check({7'h00, cycles - c0 == COM_STEP}, 8'h01);
        check(8'(n_frame), 8'h00);
        summarize();
    end
endmodule
`default_nettype wire
